/* File: hdl/rtc_counter_wait_access.v */
// Calendar counters with a software wait control and held overflow.
// Assumes sys_clk is the operating clock; tick_enable is the count rate.
// Notes on behaviour
// - Wait bit set halts seconds-through-year counters.
// - Sub-second counter keeps running during wait.
// - Wait status rises within one clock.
// - Overflow during wait held, applied after release.
// - Seconds write discards a held overflow.
// - After standby wake, status may take two.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_wait_regs.vh"
module rtc_counter_wait_access (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Count rate and standby return
  input wire tick_enable,
  input wire standby_return,
  // Control from software
  input wire counter_wait_control,
  input wire [2:0] write_select,
  input wire write_strobe,
  input wire [7:0] write_data,
  // Status and counter values
  output reg wait_status_flag,
  output reg [`SUBSEC_WIDTH-1:0] subsecond,
  output reg [`SEC_WIDTH-1:0] seconds_out,
  output reg [`MIN_WIDTH-1:0] minutes_out,
  output reg [`HOUR_WIDTH-1:0] hours_out,
  output reg [`DAY_WIDTH-1:0] days_out,
  output reg [`MONTH_WIDTH-1:0] months_out,
  output reg [`YEAR_WIDTH-1:0] years_out
);
  localparam SEL_SEC = 3'h0;
  localparam SEL_MIN = 3'h1;
  localparam SEL_HOUR = 3'h2;
  localparam SEL_DAY = 3'h3;
  localparam SEL_MONTH = 3'h4;
  localparam SEL_YEAR = 3'h5;
  localparam ST_RUN = 2'h0;
  localparam ST_SYNC = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg wake_window;
  reg held_overflow;
  wire overflow;
  wire halted;
  wire carry_sec;
  wire [5:0] carry;
  wire [5:0] load;
  wire [`SEC_WIDTH-1:0] sec_v;
  wire [`MIN_WIDTH-1:0] min_v;
  wire [`HOUR_WIDTH-1:0] hour_v;
  wire [`DAY_WIDTH-1:0] day_v;
  wire [`MONTH_WIDTH-1:0] month_v;
  wire [`YEAR_WIDTH-1:0] year_v;

  function wr_hit;
    input [2:0] sel;
    input [2:0] which;
    input strobe;
    begin
      wr_hit = strobe && (sel == which);
    end
  endfunction

  assign overflow = tick_enable && (subsecond == `SUBSEC_TOP);
  assign halted = counter_wait_control || (state != ST_RUN);
  // Held overflow replays once the wait ends
  assign carry_sec = !halted && (overflow || held_overflow);
  assign carry[0] = carry_sec;

  // Only writes while halted are honoured; software holds wait for access
  assign load[0] = wr_hit(write_select, SEL_SEC, write_strobe) && halted;
  assign load[1] = wr_hit(write_select, SEL_MIN, write_strobe) && halted;
  assign load[2] = wr_hit(write_select, SEL_HOUR, write_strobe) && halted;
  assign load[3] = wr_hit(write_select, SEL_DAY, write_strobe) && halted;
  assign load[4] = wr_hit(write_select, SEL_MONTH, write_strobe) && halted;
  assign load[5] = wr_hit(write_select, SEL_YEAR, write_strobe) && halted;

  // Sub-second counter never halts
  always @(posedge sys_clk)
  begin
    if (reset)
      subsecond <= `SUBSEC_RESET;
    else if (tick_enable)
      subsecond <= subsecond + 16'h0001;
  end

  always @(posedge sys_clk)
  begin
    if (reset)
      held_overflow <= 1'b0;
    else if (load[0])
      held_overflow <= 1'b0;
    else if (halted && overflow)
      held_overflow <= 1'b1;
    // A fresh overflow in the replay cycle stays pending for the next one
    else if (carry_sec && !overflow)
      held_overflow <= 1'b0;
  end

  // Remember a standby return for one cycle so a wait request right after it syncs
  always @(posedge sys_clk)
  begin
    if (reset)
      wake_window <= 1'b0;
    else
      wake_window <= standby_return;
  end

  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (counter_wait_control)
          next_state = (wake_window || standby_return) ? ST_SYNC : ST_WAIT;
      ST_SYNC:
        next_state = counter_wait_control ? ST_WAIT : ST_RUN;
      ST_WAIT:
        if (!counter_wait_control)
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      state <= ST_RUN;
      wait_status_flag <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // Flag follows the wait state with no extra register stage
      wait_status_flag <= (next_state == ST_WAIT);
    end
  end

  // Seconds carry ripples up to years; each digit wraps on its own
  calendar_digit #(.WIDTH(`SEC_WIDTH), .LAST(`SEC_LAST)) u_sec (
    .sys_clk(sys_clk),
    .reset(reset),
    .carry_in(carry[0]),
    .load(load[0]),
    .load_value(write_data[`SEC_WIDTH-1:0]),
    .value(sec_v),
    .carry_out(carry[1])
  );
  calendar_digit #(.WIDTH(`MIN_WIDTH), .LAST(`MIN_LAST)) u_min (
    .sys_clk(sys_clk),
    .reset(reset),
    .carry_in(carry[1]),
    .load(load[1]),
    .load_value(write_data[`MIN_WIDTH-1:0]),
    .value(min_v),
    .carry_out(carry[2])
  );
  calendar_digit #(.WIDTH(`HOUR_WIDTH), .LAST(`HOUR_LAST)) u_hour (
    .sys_clk(sys_clk),
    .reset(reset),
    .carry_in(carry[2]),
    .load(load[2]),
    .load_value(write_data[`HOUR_WIDTH-1:0]),
    .value(hour_v),
    .carry_out(carry[3])
  );
  calendar_digit #(.WIDTH(`DAY_WIDTH), .FIRST(`DAY_FIRST),
    .LAST(`DAY_LAST)) u_day (
    .sys_clk(sys_clk),
    .reset(reset),
    .carry_in(carry[3]),
    .load(load[3]),
    .load_value(write_data[`DAY_WIDTH-1:0]),
    .value(day_v),
    .carry_out(carry[4])
  );
  calendar_digit #(.WIDTH(`MONTH_WIDTH), .FIRST(`MONTH_FIRST),
    .LAST(`MONTH_LAST)) u_month (
    .sys_clk(sys_clk),
    .reset(reset),
    .carry_in(carry[4]),
    .load(load[4]),
    .load_value(write_data[`MONTH_WIDTH-1:0]),
    .value(month_v),
    .carry_out(carry[5])
  );
  calendar_digit #(.WIDTH(`YEAR_WIDTH), .LAST(`YEAR_LAST)) u_year (
    .sys_clk(sys_clk),
    .reset(reset),
    .carry_in(carry[5]),
    .load(load[5]),
    .load_value(write_data[`YEAR_WIDTH-1:0]),
    .value(year_v),
    .carry_out()
  );

  // Output copies keep every port straight from a flip-flop
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      seconds_out <= {`SEC_WIDTH{1'b0}};
      minutes_out <= {`MIN_WIDTH{1'b0}};
      hours_out <= {`HOUR_WIDTH{1'b0}};
      days_out <= `DAY_FIRST;
      months_out <= `MONTH_FIRST;
      years_out <= {`YEAR_WIDTH{1'b0}};
    end
    else
    begin
      seconds_out <= sec_v;
      minutes_out <= min_v;
      hours_out <= hour_v;
      days_out <= day_v;
      months_out <= month_v;
      years_out <= year_v;
    end
  end
endmodule // rtc_counter_wait_access
`default_nettype wire

/* File: shared/rtc_wait_regs.vh */
// Constants for the calendar counter wait-control block.
// Assumes one system clock; no bus, no registers reached by software.
`ifndef RTC_WAIT_REGS_VH
`define RTC_WAIT_REGS_VH
`define SUBSEC_WIDTH 16
`define SUBSEC_RESET 16'h0000
`define SUBSEC_TOP 16'hFFFF
`define SEC_WIDTH 6
`define MIN_WIDTH 6
`define HOUR_WIDTH 5
`define DAY_WIDTH 5
`define MONTH_WIDTH 4
`define YEAR_WIDTH 8
`define SEC_LAST 6'h3B
`define MIN_LAST 6'h3B
`define HOUR_LAST 5'h17
`define DAY_LAST 5'h1F
`define MONTH_LAST 4'hC
`define YEAR_LAST 8'h63
`define DAY_FIRST 5'h01
`define MONTH_FIRST 4'h1
`define WAIT_ACK_CYCLES 2'h1
`define WAIT_ACK_CYCLES_WAKE 2'h2
`endif

/* File: hdl/calendar_digit.v */
// One calendar digit: wraps from last to first on a carry-in.
// Assumes the caller gates carry_in with the wait state.
`timescale 1ns/1ns
`default_nettype none
module calendar_digit #(
  parameter WIDTH = 6,
  parameter [WIDTH-1:0] FIRST = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] LAST = {WIDTH{1'b1}}
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Count control
  input wire carry_in,
  input wire load,
  input wire [WIDTH-1:0] load_value,
  // State
  output reg [WIDTH-1:0] value,
  output wire carry_out
);
  assign carry_out = carry_in && (value == LAST);

  always @(posedge sys_clk)
  begin
    if (reset)
      value <= FIRST;
    else if (load)
      value <= load_value;
    else if (carry_in)
      value <= (value == LAST) ? FIRST : value + {{(WIDTH-1){1'b0}}, 1'b1};
  end
endmodule // calendar_digit
`default_nettype wire

/* File: dv/rtc_wait_props.sv */
// Port checker for the calendar wait-control block.
// Bound to the top module; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module rtc_wait_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Inputs
  input wire logic tick_enable,
  input wire logic standby_return,
  input wire logic counter_wait_control,
  input wire logic [2:0] write_select,
  input wire logic write_strobe,
  input wire logic [7:0] write_data,
  // Outputs
  input wire logic wait_status_flag,
  input wire logic [15:0] subsecond,
  input wire logic [5:0] seconds_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire cw = counter_wait_control;
  wire fl = wait_status_flag;
  wire ws = write_strobe;
  a_flag_rise: assert property (
    $rose(cw) && !standby_return && !$past(standby_return) |=> fl)
    else $error("flag late");
  a_wake_rise: assert property ($rose(cw) |-> ##[1:2] fl)
    else $error("flag late after wake");
  a_flag_fall: assert property ($fell(cw) |=> !fl)
    else $error("flag stuck");
  a_flag_cause: assert property ($rose(fl) |-> $past(cw))
    else $error("flag without wait");
  a_sub_step: assert property (
    1 |=> subsecond == 16'($past(subsecond) + $past(tick_enable)))
    else $error("subsecond step");
  a_frozen_sec: assert property (
    fl && $past(fl, 2) && cw && $past(cw) && !$past(ws) &&
    !$past(ws, 2) |-> $stable(seconds_out))
    else $error("seconds moved in wait");
  a_write_land: assert property (
    fl && cw && ws && write_select == 3'h0 |->
    ##2 seconds_out == $past(write_data[5:0], 2))
    else $error("write lost");
  // Quiet wait history rules out a replayed held second; the subsecond range rules out a fresh overflow
  a_write_refused: assert property (
    !cw && !$past(cw) && !$past(cw, 2) && !$past(cw, 3) && !fl && ws &&
    subsecond != 16'h0000 && subsecond < 16'hFFF0 |->
    ##2 seconds_out == $past(seconds_out, 2))
    else $error("write taken while running");
  c_wake: cover property ($rose(cw) && standby_return);
  c_write: cover property (fl && ws);
  c_held: cover property (fl && tick_enable && subsecond == 16'hFFFF);
endmodule // rtc_wait_props
bind rtc_counter_wait_access rtc_wait_props u_rtc_wait_props (.sys_clk,
  .reset, .tick_enable, .standby_return, .counter_wait_control,
  .write_select, .write_strobe, .write_data, .wait_status_flag,
  .subsecond, .seconds_out);
`default_nettype wire

/* File: dv/rtc_counter_wait_access_tb.sv */
// Bench with a counter model for the wait-control block.
// Drives all ports itself; tick every cycle once running.
`timescale 1ns/1ns
`default_nettype none
module rtc_counter_wait_access_tb;
  logic sys_clk = 1'b0, reset = 1'b1, tick_enable = 1'b0;
  logic standby_return = 1'b0, counter_wait_control = 1'b0;
  logic write_strobe = 1'b0;
  logic [2:0] write_select = 3'h0;
  logic [7:0] write_data = 8'h00, years_out;
  logic wait_status_flag;
  logic [15:0] subsecond;
  logic [5:0] seconds_out, minutes_out;
  logic [4:0] hours_out, days_out;
  logic [3:0] months_out;
  int n_mismatch = 0, n_checks = 0, msub = 0;
  int m[6] = '{0, 0, 0, 1, 1, 0};
  int hi[6] = '{58, 59, 23, 31, 12, 99};
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (!reset && tick_enable)
      msub <= (msub + 1) % 65536;
  rtc_counter_wait_access u_rtc_counter_wait_access (.sys_clk, .reset,
    .tick_enable, .standby_return, .counter_wait_control, .write_select,
    .write_strobe, .write_data, .wait_status_flag, .subsecond,
    .seconds_out, .minutes_out, .hours_out, .days_out, .months_out,
    .years_out);
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmp(input string what, input logic [33:0] exp,
    input logic [33:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_cnt();
    cmp("sub", 34'(msub), 34'(subsecond));
    cmp("counters", {m[0][5:0], m[1][5:0], m[2][4:0], m[3][4:0],
      m[4][3:0], m[5][7:0]}, {seconds_out, minutes_out, hours_out,
      days_out, months_out, years_out});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #1400000;
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(93410));
    step(4);
    reset = 1'b0;
    cmp("flag", 34'h0, 34'(wait_status_flag));
    chk_cnt();
    tick_enable = 1'b1;
    counter_wait_control = 1'b1;
    step(1);
    cmp("flag", 34'h1, 34'(wait_status_flag));
    counter_wait_control = 1'b0;
    step(1);
    cmp("flag", 34'h0, 34'(wait_status_flag));
    step(2);
    standby_return = 1'b1;
    counter_wait_control = 1'b1;
    step(1);
    standby_return = 1'b0;
    step(1);
    cmp("flag", 34'h1, 34'(wait_status_flag));
    // Back-to-back writes to every counter, only once the flag is up
    write_strobe = 1'b1;
    for (int s = 0; s < 6; s++)
    begin
      write_select = 3'(s);
      m[s] = $urandom_range(hi[s], (s == 3 || s == 4) ? 1 : 0);
      write_data = 8'(m[s]);
      step(1);
    end
    write_strobe = 1'b0;
    step(8);
    chk_cnt();
    counter_wait_control = 1'b0;
    // Three idle cycles keep the refused write clear of the wait's end
    step(3);
    // Running write must be ignored
    write_strobe = 1'b1;
    write_data = 8'h3B;
    write_select = 3'h0;
    step(1);
    write_strobe = 1'b0;
    step(3);
    chk_cnt();
    // Overflow lands inside a wait and is replayed
    while (msub < 65520)
      step(1);
    counter_wait_control = 1'b1;
    step(40);
    chk_cnt();
    counter_wait_control = 1'b0;
    m[0]++;
    step(4);
    chk_cnt();
    give_verdict();
  end
endmodule // rtc_counter_wait_access_tb
`default_nettype wire
